// File: verilog/udb_defines.svh
// Constants for the serial data buffer and baud clock selection block.
// Assumes inclusion by bare name from the design files under verilog/.
`ifndef UDB_DEFINES_SVH
`define UDB_DEFINES_SVH

// Register address of the serial data buffer on the special-function bus.
`define UDB_SBUF_ADDR      8'h99
// Reset value of the receive latch and transmit register.
`define UDB_SBUF_RESET     8'h00
// Prescale select codes.
`define UDB_PRE_DIV12      2'h0
`define UDB_PRE_DIV4       2'h1
`define UDB_PRE_DIV48      2'h2
`define UDB_PRE_EXT8       2'h3
// Division ratios of the prescaler, less one.
`define UDB_DIV4_LAST      6'h03
`define UDB_DIV12_LAST     6'h0b
`define UDB_DIV48_LAST     6'h2f
`define UDB_EXT8_LAST      3'h7
// Overflow toggle level at which the bit tick fires; two overflows make one bit period.
`define UDB_OVF_PER_BIT    1'h1

`endif

// File: verilog/udb_pkg.sv
// Types shared by the serial data buffer block.
// Assumes udb_defines.svh holds all numeric constants.
`default_nettype none

package udb_pkg;

  // Baud clock configuration carried as one group.
  typedef struct packed {
    logic       direct_system_clock_source; // Timer counts undivided system clock when set.
    logic [1:0] prescale;      // Prescale select code.
    logic [7:0] reload;        // Timer reload value.
  } udb_baud_cfg_t;

  // Transmitter states.
  typedef enum logic [1:0] {
    UDB_TX_IDLE  = 2'b00,
    UDB_TX_START = 2'b01,
    UDB_TX_DATA  = 2'b10,
    UDB_TX_STOP  = 2'b11
  } udb_tx_state_t;

  // Receiver states.
  typedef enum logic [1:0] {
    UDB_RX_IDLE  = 2'b00,
    UDB_RX_START = 2'b01,
    UDB_RX_DATA  = 2'b10,
    UDB_RX_STOP  = 2'b11
  } udb_rx_state_t;

endpackage : udb_pkg
`default_nettype wire

// File: verilog/udb_baud_gen.sv
// Baud tick generator: prescaler plus 8-bit reload timer.
// Assumes the external oscillator input is already synchronised to core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "udb_defines.svh"

module udb_baud_gen (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire udb_pkg::udb_baud_cfg_t cfg,
  input  wire logic                  ext_clk_sync,
  output logic                       bit_tick
);
  import udb_pkg::*;

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [5:0] pre_cnt;    // System clock divider count.
  logic [5:0] pre_last;   // Terminal count for the selected ratio.
  logic [2:0] ext_cnt;    // External clock edge count.
  logic       ext_prev;   // Previous synchronised external level.
  logic       timer_en;   // One-cycle timer clock enable.
  logic [7:0] timer;      // Reload timer.
  logic       ovf_half;   // Toggles on each overflow.

  // Terminal count chosen from the prescale code.
  always_comb
  begin
    case (cfg.prescale)
      `UDB_PRE_DIV4:  pre_last = `UDB_DIV4_LAST;
      `UDB_PRE_DIV48: pre_last = `UDB_DIV48_LAST;
      default:        pre_last = `UDB_DIV12_LAST;
    endcase
  end

  // System clock divider.
  always_ff @(posedge core_clk)
  begin
    if (!resetn || pre_cnt >= pre_last)
      pre_cnt <= 6'h00;
    else
      pre_cnt <= pre_cnt + 6'h01;
  end

  // External oscillator divider counts rising edges.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      ext_cnt  <= 3'h0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_prev <= ext_clk_sync;
      if (ext_clk_sync && !ext_prev)
        ext_cnt <= ext_cnt + 3'h1;
    end
  end

  // Select the timer clock source.
  always_comb
  begin
    if (cfg.direct_system_clock_source)
      timer_en = 1'b1;
    else if (cfg.prescale == `UDB_PRE_EXT8)
      timer_en = ext_clk_sync && !ext_prev && ext_cnt == `UDB_EXT8_LAST;
    else
      timer_en = (pre_cnt >= pre_last);
  end

  // ---------------------------------------------------------------
  // Reload timer, two overflows per bit
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      timer    <= 8'h00;
      ovf_half <= 1'b0;
      bit_tick <= 1'b0;
    end
    else
    begin
      bit_tick <= 1'b0;
      if (timer_en)
      begin
        if (timer == 8'hff)
        begin
          timer    <= cfg.reload;
          ovf_half <= ~ovf_half;
          bit_tick <= ovf_half == `UDB_OVF_PER_BIT;
        end
        else
          timer <= timer + 8'h01;
      end
    end
  end

endmodule : udb_baud_gen
`default_nettype wire

// File: verilog/udb_serial_port.sv
// Serial port data buffer with baud clock selection.
// Assumes a single-cycle special-function bus on core_clk; line pins are asynchronous.
//
// Notes on behaviour
// - One address: write transmit, read receive.
// - Writing the buffer starts transmission.
// - Reads return the receive latch.
// - Prescale codes select divide 12, 4, 48.
// - Code 11 uses external clock over eight.
// - Direct select counts undivided clock.
// - Transmit flag set after data, held.
// - Receive flag set at stop sample.
`timescale 1ns/10ps
`default_nettype none
`include "udb_defines.svh"

module udb_serial_port (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic [7:0]             sfr_addr,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic [7:0]                  sfr_rdata,
  input  wire udb_pkg::udb_baud_cfg_t baud_cfg,
  input  wire logic                   nine_bit_mode,
  input  wire logic                   ninth_tx_bit,
  input  wire logic                   receive_enable,
  input  wire logic                   transmit_done_clear,
  input  wire logic                   receive_done_clear,
  input  wire logic                   external_oscillator_clock,
  input  wire logic                   rx_pin,
  output logic                        tx_pin,
  output logic                        transmit_done_flag,
  output logic                        receive_done_flag,
  output logic                        ninth_rx_bit
);
  import udb_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rx_sync;    // Receive pin, two stages.
  logic [1:0] ext_sync;   // External oscillator, two stages.
  logic       bit_tick;   // One tick per bit period.

  // Two-stage synchronisers; only stage two feeds logic, so no metastable level spreads.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_sync  <= 2'b11;
      ext_sync <= 2'b00;
    end
    else
    begin
      rx_sync  <= {rx_sync[0], rx_pin};
      ext_sync <= {ext_sync[0], external_oscillator_clock};
    end
  end

  // Baud clock generator.
  udb_baud_gen u_baud (
    .core_clk     (core_clk),
    .resetn       (resetn),
    .cfg          (baud_cfg),
    .ext_clk_sync (ext_sync[1]),
    .bit_tick     (bit_tick)
  );

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  logic [7:0] tx_shift;   // Transmit shift register.
  logic [7:0] rx_latch;   // Receive latch.
  logic       wr_hit;     // Write to the data buffer address.

  assign wr_hit = sfr_wr && sfr_addr == `UDB_SBUF_ADDR;

  // Read data: the receive latch only, zero elsewhere.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      sfr_rdata <= `UDB_SBUF_RESET;
    else if (sfr_rd && sfr_addr == `UDB_SBUF_ADDR)
      sfr_rdata <= rx_latch;
    else
      sfr_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  udb_tx_state_t tx_state;  // Transmit state.
  logic [3:0]    tx_cnt;    // Data bits sent.
  logic          tx_set;    // Transmit done event.

  // Frame sequencer; a write restarts the frame at once.
  always_ff @(posedge core_clk)
  begin
    tx_set <= 1'b0;
    if (!resetn)
    begin
      tx_state <= UDB_TX_IDLE;
      tx_shift <= `UDB_SBUF_RESET;
      tx_cnt   <= 4'h0;
      tx_pin   <= 1'b1;
    end
    else if (wr_hit)
    begin
      tx_shift <= sfr_wdata;
      tx_cnt   <= 4'h0;
      tx_state <= UDB_TX_START;
    end
    else if (bit_tick)
    begin
      case (tx_state)
        UDB_TX_START:
        begin
          tx_pin   <= 1'b0;
          tx_state <= UDB_TX_DATA;
        end
        UDB_TX_DATA:
        begin
          // The last data bit has gone out: drive the stop level and raise the flag.
          if (tx_cnt == (nine_bit_mode ? 4'h9 : 4'h8))
          begin
            tx_pin   <= 1'b1;
            tx_state <= UDB_TX_STOP;
            tx_set   <= 1'b1;
          end
          // Bit seven goes out; the ninth bit is queued behind it for nine-bit frames.
          else if (tx_cnt == 4'h7)
          begin
            tx_pin   <= tx_shift[0];
            tx_shift <= {7'h00, ninth_tx_bit};
            tx_cnt   <= 4'h8;
          end
          else
          begin
            tx_pin   <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_cnt   <= tx_cnt + 4'h1;
          end
        end
        UDB_TX_STOP:
        begin
          tx_pin   <= 1'b1;
          tx_state <= UDB_TX_IDLE;
        end
        default:
          tx_pin <= 1'b1;
      endcase
    end
  end

  // Sticky transmit flag; set wins over clear.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      transmit_done_flag <= 1'b0;
    else if (tx_set)
      transmit_done_flag <= 1'b1;
    else if (transmit_done_clear)
      transmit_done_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Receiver, one sample per bit tick
  // ---------------------------------------------------------------
  udb_rx_state_t rx_state;  // Receive state.
  logic [3:0]    rx_cnt;    // Data bits taken.
  logic [8:0]    rx_shift;  // Incoming bits.
  logic          rx_set;    // Receive done event.

  // Receive sequencer.
  always_ff @(posedge core_clk)
  begin
    rx_set <= 1'b0;
    if (!resetn)
    begin
      rx_state     <= UDB_RX_IDLE;
      rx_cnt       <= 4'h0;
      rx_shift     <= 9'h000;
      rx_latch     <= `UDB_SBUF_RESET;
      ninth_rx_bit <= 1'b0;
    end
    else if (bit_tick)
    begin
      case (rx_state)
        UDB_RX_IDLE:
          if (receive_enable && !rx_sync[1])
            rx_state <= UDB_RX_DATA;
        UDB_RX_DATA:
        begin
          rx_shift <= {rx_sync[1], rx_shift[8:1]};
          if (rx_cnt == (nine_bit_mode ? 4'h8 : 4'h7))
          begin
            rx_cnt   <= 4'h0;
            rx_state <= UDB_RX_STOP;
          end
          else
            rx_cnt <= rx_cnt + 4'h1;
        end
        UDB_RX_STOP:
        begin
          rx_latch     <= nine_bit_mode ? rx_shift[7:0] : rx_shift[8:1];
          ninth_rx_bit <= nine_bit_mode ? rx_shift[8] : rx_sync[1];
          rx_set       <= 1'b1;
          rx_state     <= UDB_RX_IDLE;
        end
        default:
          rx_state <= UDB_RX_IDLE;
      endcase
    end
  end

  // Sticky receive flag; set wins over clear.
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      receive_done_flag <= 1'b0;
    else if (rx_set)
      receive_done_flag <= 1'b1;
    else if (receive_done_clear)
      receive_done_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  // Write starts a frame next cycle.
  a_write_starts_frame: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hit |=> tx_state == UDB_TX_START)
    else $error("write did not start a frame");

  // Written byte lands in the transmit register.
  a_write_loads_tx: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_hit |=> tx_shift == $past(sfr_wdata))
    else $error("transmit register not loaded");

  // Read returns the receive latch.
  a_read_returns_rx: assert property (@(posedge core_clk) disable iff (!resetn)
    (sfr_rd && sfr_addr == `UDB_SBUF_ADDR) |=> sfr_rdata == $past(rx_latch))
    else $error("read did not return receive latch");

  // Transmit flag holds until cleared.
  a_tx_flag_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
    (transmit_done_flag && !transmit_done_clear) |=> transmit_done_flag)
    else $error("transmit flag dropped");

  // Transmit event raises the flag.
  a_tx_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
    tx_set |=> transmit_done_flag)
    else $error("transmit flag not set");

  // Receive event raises the flag next cycle.
  a_rx_flag_set: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_set |=> receive_done_flag)
    else $error("receive flag not set");

  // Receive event follows a stop sample.
  a_rx_after_stop: assert property (@(posedge core_clk) disable iff (!resetn)
    rx_set |-> $past(rx_state) == UDB_RX_STOP && $past(bit_tick))
    else $error("receive flag without stop sample");

  // Direct mode with a steady configuration never gives bit ticks on consecutive cycles.
  a_tick_spacing: assert property (@(posedge core_clk) disable iff (!resetn)
    (bit_tick && baud_cfg.direct_system_clock_source && $stable(baud_cfg)) |=> !bit_tick)
    else $error("bit ticks too close");

endmodule : udb_serial_port
`default_nettype wire

// File: dv/udb_remote_model.sv
// Remote serial transceiver model for the line side of the data buffer block.
// Assumes the bench sets bit_cycles to the bit period in core_clk cycles.
`timescale 1ns/10ps
`default_nettype none

module udb_remote_model (
  input  wire logic core_clk,
  input  wire logic line_in,
  output var logic  line_out
);
  int         bit_cycles = 8;  // Bit period in clock cycles.
  logic       nine = 1'b0;     // Nine data bits per frame when set.
  logic [8:0] got_bits = '0;   // Last frame captured from the device.
  int         got_count = 0;   // Frames captured so far.

  // The line idles at the mark level, as a pulled-up serial line does.
  initial line_out = 1'b1;

  // ----
  // Capture
  // ----
  // Samples each bit in its middle, LSB first, so small phase slips do not matter.
  always
  begin
    @(negedge line_in);
    repeat (bit_cycles / 2) @(posedge core_clk);
    for (int i = 0; i < 9; i++)
    begin
      if (i < 8 || nine)
      begin
        repeat (bit_cycles) @(posedge core_clk);
        got_bits[i] = line_in;
      end
    end
    got_count++;
    repeat (bit_cycles) @(posedge core_clk);
  end

  // ----
  // Send
  // ----
  // Sends start, data LSB first, an optional ninth bit and a stop bit.
  task automatic send_frame(input logic [7:0] data, input logic ninth);
    logic [10:0] frame;
    frame = {1'b1, nine ? ninth : 1'b1, data, 1'b0};
    @(posedge core_clk);
    for (int i = 0; i < (nine ? 11 : 10); i++)
    begin
      line_out <= frame[i];
      repeat (bit_cycles) @(posedge core_clk);
    end
  endtask : send_frame

endmodule : udb_remote_model
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the serial data buffer and baud clock selection.
// Assumes the remote model in udb_remote_model.sv stands on the line pins.
`timescale 1ns/10ps
`default_nettype none
`include "udb_defines.svh"

module tb_top;
  import udb_pkg::*;
  logic core_clk = 1'b0, resetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata, rd;
  udb_baud_cfg_t baud_cfg = '{1'b1, 2'h0, 8'hfc};
  logic nine_bit_mode = 1'b0, ninth_tx_bit = 1'b0, receive_enable = 1'b1;
  logic tx_clr = 1'b0, rx_clr = 1'b0, ext_clk = 1'b0, rx_pin, tx_pin;
  logic tx_flag, rx_flag, ninth_rx_bit, ok;
  logic [15:0] low_len, d8, d9;
  int fail_count = 0, compares = 0, cycles = 0, ext_cnt = 0;
  // Baud table: direct select, prescale code, reload, bit period in cycles.
  logic direct_t [6] = '{1, 0, 0, 0, 0, 1};
  logic [1:0] pre_t [6] = '{0, 0, 1, 2, 3, 3};
  logic [7:0] rel_t [6] = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfe};
  int bp_t [6] = '{4, 24, 8, 96, 96, 4};

  udb_serial_port dut (.core_clk(core_clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_cfg(baud_cfg),
    .nine_bit_mode(nine_bit_mode), .ninth_tx_bit(ninth_tx_bit), .receive_enable(receive_enable),
    .transmit_done_clear(tx_clr), .receive_done_clear(rx_clr), .external_oscillator_clock(ext_clk),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .transmit_done_flag(tx_flag), .receive_done_flag(rx_flag),
    .ninth_rx_bit(ninth_rx_bit));
  udb_remote_model remote (.core_clk(core_clk), .line_in(tx_pin), .line_out(rx_pin));

  // 200 MHz clock.
  always #2.5 core_clk = ~core_clk;

  // External oscillator with a period of six clocks; the watchdog cuts a hang short.
  always @(posedge core_clk)
  begin
    ext_cnt <= (ext_cnt == 2) ? 0 : ext_cnt + 1;
    if (ext_cnt == 2) ext_clk <= ~ext_clk;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ----
  // Tasks
  // ----
  // Compares a seen value with the expected one and counts the result.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Moves to just after the next rising edge, where outputs have settled.
  task automatic step;
    @(posedge core_clk);
    #1;
  endtask : step

  // One bus access; the strobe is taken at the second edge and read data is taken just after it.
  task automatic bus(input logic [7:0] addr, input logic [7:0] data, input logic wr);
    @(posedge core_clk);
    sfr_addr <= addr;
    sfr_wdata <= data;
    sfr_wr <= wr;
    sfr_rd <= ~wr;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    #1 rd = sfr_rdata;
  endtask : bus

  // Sends one byte, measures the start bit and the delay to the done flag, then clears it.
  task automatic tx_frame(input logic [7:0] data);
    int c0;
    c0 = remote.got_count;
    bus(`UDB_SBUF_ADDR, data, 1'b1);
    low_len = '0;
    while (tx_pin === 1'b1) step();
    while (tx_pin === 1'b0)
    begin
      step();
      low_len++;
    end
    d9 = low_len;
    while (tx_flag !== 1'b1)
    begin
      step();
      d9++;
    end
    repeat (3) step();
    check(16'(tx_flag), 16'h1);
    @(posedge core_clk) tx_clr <= 1'b1;
    @(posedge core_clk) tx_clr <= 1'b0;
    #1 check(16'(tx_flag), 16'h0);
    while (remote.got_count == c0) step();
  endtask : tx_frame

  // Ends the run with the verdict.
  task automatic close_out;
    if (fail_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    step();
    check(16'({tx_pin, tx_flag, rx_flag}), 16'h4);
    bus(`UDB_SBUF_ADDR, 8'h00, 1'b0);
    check(16'(rd), 16'h00);
    // An unmapped address neither sends nor reads back.
    bus(8'h98, 8'h5a, 1'b1);
    ok = 1'b1;
    repeat (40) begin step(); if (tx_pin !== 1'b1) ok = 1'b0; end
    check(16'(ok), 16'h1);
    bus(8'h98, 8'h00, 1'b0);
    check(16'(rd), 16'h00);
    // Eight-bit send, then nine-bit send; the flag moves one bit later.
    tx_frame(8'ha5);
    d8 = d9;
    check(16'(remote.got_bits[7:0]), 16'ha5);
    bus(`UDB_SBUF_ADDR, 8'h00, 1'b0);
    check(16'(rd), 16'h00);
    nine_bit_mode <= 1'b1;
    ninth_tx_bit <= 1'b1;
    remote.nine = 1'b1;
    tx_frame(8'h3c);
    check(16'(remote.got_bits), 16'h13c);
    check(d9 - d8, 16'd8);
    nine_bit_mode <= 1'b0;
    remote.nine = 1'b0;
    // Receive while a byte is written and sent out in the same frame time.
    fork
      remote.send_frame(8'h3c, 1'b0);
      begin repeat (20) step(); bus(`UDB_SBUF_ADDR, 8'h55, 1'b1); end
    join
    for (int n = 0; n < 100 && rx_flag !== 1'b1; n++) step();
    check(16'({rx_flag, ninth_rx_bit}), 16'h3);
    bus(`UDB_SBUF_ADDR, 8'h00, 1'b0);
    check(16'(rd), 16'h3c);
    for (int n = 0; n < 200 && tx_flag !== 1'b1; n++) step();
    check(16'(remote.got_bits[7:0]), 16'h55);
    @(posedge core_clk) rx_clr <= 1'b1;
    tx_clr <= 1'b1;
    @(posedge core_clk) rx_clr <= 1'b0;
    tx_clr <= 1'b0;
    // No new frame is taken while reception is off.
    receive_enable <= 1'b0;
    remote.send_frame(8'h77, 1'b0);
    repeat (20) step();
    bus(`UDB_SBUF_ADDR, 8'h00, 1'b0);
    check(16'({rx_flag, rd}), 16'h3c);
    // Nine-bit receive: the ninth data bit lands beside the byte, not the stop bit.
    receive_enable <= 1'b1;
    nine_bit_mode <= 1'b1;
    remote.nine = 1'b1;
    remote.send_frame(8'hc3, 1'b0);
    for (int n = 0; n < 100 && rx_flag !== 1'b1; n++) step();
    bus(`UDB_SBUF_ADDR, 8'h00, 1'b0);
    check(16'({rx_flag, ninth_rx_bit, rd}), 16'h2c3);
    nine_bit_mode <= 1'b0;
    remote.nine = 1'b0;
    // Every prescale code, and the direct select overriding it.
    for (int k = 0; k < 6; k++)
    begin
      baud_cfg <= '{direct_t[k], pre_t[k], rel_t[k]};
      remote.bit_cycles = bp_t[k];
      repeat (300) step();
      tx_frame(8'h01);
      check(low_len, 16'(bp_t[k]));
    end
    close_out();
  end

endmodule : tb_top
`default_nettype wire
